//--- design/led_cmd_defs.svh
// constants of the bus command decoder
`ifndef LED_CMD_DEFS_SVH
`define LED_CMD_DEFS_SVH
`define CMD_WRITE_CHANNEL_CONFIG 8'h00
`define CMD_WRITE_GAINS 8'h01
`define CMD_WRITE_CONFIG_AND_GAINS 8'h02
`define CMD_WRITE_PRESCALER_BIT 8'h03
`define CMD_READ_STATUS 8'h08
`define CMD_READ_FAULTS 8'h09
`define CMD_READ_EVERYTHING 8'h0a
`define CMD_READ_GAINS 8'h0b
`define CMD_EMULATE_ONETIME_SETTINGS 8'h20
`define CMD_PROGRAM_ONETIME_CELLS 8'h21
`define CMD_READ_ONETIME_CELLS 8'h28
`define CMD_DIRECT_REGISTER_ACCESS 8'h81
`define REG_CHAN_CFG1 8'h00
`define REG_CHAN_CFG2 8'h01
`define REG_GAIN_BASE 8'h02
`define REG_FAULT1 8'h0e
`define REG_FAULT2 8'h0f
`define REG_STATUS 8'h10
`define REG_ENABLE1 8'h11
`define REG_ENABLE2 8'h12
`define REG_READBACK 8'h13
`define REG_SA_BASE 8'h20
`define REG_SA_LAST 8'h23
`define GAIN_COUNT 8'h0c
`define SA_COUNT 8'h04
`define GROUP_COUNT 8'h05
`define DIRECT_LEN 8'hff
`define BUS_ADDR_HI 2'b01
`define PROTECT_BIT 7
`define PRESCALE_MASK 8'h80
`define FULL_MASK 8'hff
`endif

//--- design/led_cmd_pkg.sv
// types and nibble codeword table of the bus command decoder
package led_cmd_pkg;
  typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_MACK} link_state_t;

  function automatic logic [7:0] nib_encode(input logic [3:0] n);
    case (n)
      4'h0: nib_encode = 8'h00;
      4'h1: nib_encode = 8'h1e;
      4'h2: nib_encode = 8'h27;
      4'h3: nib_encode = 8'h39;
      4'h4: nib_encode = 8'h55;
      4'h5: nib_encode = 8'h4b;
      4'h6: nib_encode = 8'h72;
      4'h7: nib_encode = 8'h6c;
      4'h8: nib_encode = 8'h93;
      4'h9: nib_encode = 8'h8d;
      4'ha: nib_encode = 8'hb4;
      4'hb: nib_encode = 8'haa;
      4'hc: nib_encode = 8'hc6;
      4'hd: nib_encode = 8'hd8;
      4'he: nib_encode = 8'he1;
      default: nib_encode = 8'hff;
    endcase
  endfunction
endpackage

//--- design/led_bus_command_decoder.sv
// bus command decoder: link bit engine, command layer, write buffer
// Operation
// - protected nibbles use fixed table codewords
// - protected bytes go high then low codeword
// - repeated address acked only when own
// - unknown command code is not acknowledged
// - channel config pair commits after second byte
// - missing second byte leaves first unchanged
// - gain bytes commit one by one
// - full write: config pair then gains
// - prescaler command writes fault bit seven
// - status command returns status register
// - fault command returns both fault registers
// - full read returns enables, status, faults, gains
// - gain read returns twelve gains
// - emulation writes standalone settings volatile
// - program command burns standalone settings
// - onetime read returns readback and settings
// - direct access reads or writes by address
// - protection follows setting byte bit seven
// - codeword check catches three flipped bits
`timescale 1ns/100ps
`include "led_cmd_defs.svh"
module led_bus_command_decoder
  import led_cmd_pkg::*;
#(
  parameter int DEPTH = 2,
  parameter int WIDTH = 25
) (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_B,
  input wire logic [7:0] SETTING_BYTE,
  output logic [7:0] RD_ADDR,
  input wire logic [7:0] RD_DATA,
  output logic WR_VALID,
  input wire logic WR_READY,
  output logic [7:0] WR_ADDR,
  output logic [7:0] WR_DATA,
  output logic [7:0] WR_MASK,
  output logic WR_BURN
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  function automatic logic [7:0] seq_len(input logic [7:0] c);
    case (c)
      `CMD_WRITE_CHANNEL_CONFIG: seq_len = 8'h02;
      `CMD_WRITE_GAINS: seq_len = `GAIN_COUNT;
      `CMD_WRITE_CONFIG_AND_GAINS: seq_len = `GAIN_COUNT + 8'h02;
      `CMD_WRITE_PRESCALER_BIT: seq_len = 8'h01;
      `CMD_READ_STATUS: seq_len = 8'h01;
      `CMD_READ_FAULTS: seq_len = 8'h02;
      `CMD_READ_EVERYTHING: seq_len = `GAIN_COUNT + `GROUP_COUNT;
      `CMD_READ_GAINS: seq_len = `GAIN_COUNT;
      `CMD_EMULATE_ONETIME_SETTINGS: seq_len = `SA_COUNT;
      `CMD_PROGRAM_ONETIME_CELLS: seq_len = `SA_COUNT;
      `CMD_READ_ONETIME_CELLS: seq_len = `SA_COUNT + 8'h01;
      `CMD_DIRECT_REGISTER_ACCESS: seq_len = `DIRECT_LEN;
      default: seq_len = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] seq_addr(input logic [7:0] c,
                                          input logic [7:0] i,
                                          input logic [7:0] p);
    case (c)
      `CMD_WRITE_GAINS, `CMD_READ_GAINS: seq_addr = `REG_GAIN_BASE + i;
      `CMD_WRITE_PRESCALER_BIT: seq_addr = `REG_FAULT1;
      `CMD_READ_STATUS: seq_addr = `REG_STATUS;
      `CMD_READ_FAULTS: seq_addr = `REG_FAULT1 + i;
      `CMD_READ_EVERYTHING: begin
        case (i)
          8'h00: seq_addr = `REG_ENABLE1;
          8'h01: seq_addr = `REG_ENABLE2;
          8'h02: seq_addr = `REG_STATUS;
          8'h03: seq_addr = `REG_FAULT1;
          8'h04: seq_addr = `REG_FAULT2;
          default: seq_addr = `REG_GAIN_BASE + i - `GROUP_COUNT;
        endcase
      end
      `CMD_EMULATE_ONETIME_SETTINGS, `CMD_PROGRAM_ONETIME_CELLS:
        seq_addr = `REG_SA_BASE + i;
      `CMD_READ_ONETIME_CELLS: begin
        if (i == 8'h00) begin
          seq_addr = `REG_READBACK;
        end else begin
          seq_addr = `REG_SA_BASE + i - 8'h01;
        end
      end
      `CMD_DIRECT_REGISTER_ACCESS: seq_addr = p + i;
      default: seq_addr = `REG_CHAN_CFG1 + i;
    endcase
  endfunction

  function automatic logic in_range(input logic [7:0] a);
    in_range = (a <= `REG_STATUS) ||
               (a >= `REG_SA_BASE && a <= `REG_SA_LAST);
  endfunction

  logic [2:0] scl_q_r, scl_q_nxt, sda_q_r, sda_q_nxt;
  link_state_t st_r, st_nxt;
  logic [3:0] bit_r, bit_nxt, nib_r, nib_nxt, cw_nib;
  logic [7:0] sh_r, sh_nxt, cmd_r, cmd_nxt, widx_r, widx_nxt;
  logic [7:0] ridx_r, ridx_nxt, ptr_r, ptr_nxt, hold_r, hold_nxt;
  logic [7:0] pdat_r, pdat_nxt, rda_r, rda_nxt;
  logic [1:0] lpos_r, lpos_nxt;
  logic oe_b_r, oe_b_nxt, half_r, half_nxt, armed_r, armed_nxt;
  logic txm_r, txm_nxt, pend_r, pend_nxt, mack_r, mack_nxt;
  logic scl_rise, scl_fall, start_ev, stop_ev, dec, ok, push, pair;
  logic ham, cw_ok, is_dir, is_wr;
  logic [6:0] own;
  logic [7:0] lb, widx_w, wa, tx_byte, tx_load;
  logic [WIDTH-1:0] push_ent;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [PW:0] cnt_r, cnt_nxt;
  logic fifo_rdy;

  // the second and third stages of each synchroniser feed logic
  assign scl_rise = scl_q_r[1] & ~scl_q_r[2];
  assign scl_fall = ~scl_q_r[1] & scl_q_r[2];
  assign start_ev = scl_q_r[1] & scl_q_r[2] & ~sda_q_r[1] & sda_q_r[2];
  assign stop_ev = scl_q_r[1] & scl_q_r[2] & sda_q_r[1] & ~sda_q_r[2];
  assign own = {`BUS_ADDR_HI, SETTING_BYTE[4:0]};
  assign ham = SETTING_BYTE[`PROTECT_BIT];
  assign dec = (st_r == S_RX) && scl_fall && (bit_r == 4'h8);
  assign is_dir = (cmd_r == `CMD_DIRECT_REGISTER_ACCESS);
  assign is_wr = (cmd_r < `CMD_READ_STATUS) || is_dir ||
                 (cmd_r == `CMD_EMULATE_ONETIME_SETTINGS) ||
                 (cmd_r == `CMD_PROGRAM_ONETIME_CELLS);
  assign pair = (cmd_r == `CMD_WRITE_CHANNEL_CONFIG) ||
                (cmd_r == `CMD_WRITE_CONFIG_AND_GAINS);
  assign widx_w = is_dir ? widx_r - 8'h01 : widx_r;
  assign wa = seq_addr(cmd_r, widx_w, ptr_r);
  assign tx_byte = (ridx_r < seq_len(cmd_r)) ? RD_DATA : 8'h00;
  assign tx_load = !ham ? tx_byte :
                   half_r ? nib_encode(tx_byte[3:0]) :
                   nib_encode(tx_byte[7:4]);
  assign fifo_rdy = (cnt_r < (PW + 1)'(DEPTH));
  assign SDA_OUT = 1'b0;
  assign SDA_OE_B = oe_b_r;
  assign RD_ADDR = rda_r;

  always_comb begin
    cw_ok = 1'b0;
    cw_nib = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (nib_encode(4'(i)) == sh_r) begin
        cw_ok = 1'b1;
        cw_nib = 4'(i);
      end
    end
  end

  assign lb = ham ? {nib_r, cw_nib} : sh_r;

  always_comb begin
    scl_q_nxt = {scl_q_r[1:0], SCL_IN};
    sda_q_nxt = {sda_q_r[1:0], SDA_IN};
    st_nxt = st_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    oe_b_nxt = oe_b_r;
    lpos_nxt = lpos_r;
    half_nxt = half_r;
    nib_nxt = nib_r;
    cmd_nxt = cmd_r;
    armed_nxt = armed_r;
    txm_nxt = txm_r;
    widx_nxt = widx_r;
    ridx_nxt = ridx_r;
    ptr_nxt = ptr_r;
    hold_nxt = hold_r;
    pend_nxt = 1'b0;
    pdat_nxt = pdat_r;
    mack_nxt = mack_r;
    rda_nxt = seq_addr(cmd_r, ridx_r, ptr_r);
    ok = 1'b0;
    push = pend_r;
    push_ent = {1'b0, `FULL_MASK, `REG_CHAN_CFG2, pdat_r};
    if (stop_ev) begin
      st_nxt = S_IDLE;
      oe_b_nxt = 1'b1;
      armed_nxt = 1'b0;
    end else if (start_ev) begin
      st_nxt = S_RX;
      bit_nxt = 4'h0;
      oe_b_nxt = 1'b1;
      lpos_nxt = 2'd0;
      half_nxt = 1'b0;
    end else begin
      case (st_r)
        S_RX: begin
          if (scl_rise) begin
            sh_nxt = {sh_r[6:0], sda_q_r[1]};
            bit_nxt = bit_r + 4'h1;
          end
          if (dec) begin
            txm_nxt = 1'b0;
            if (lpos_r == 2'd0) begin
              if (sh_r[7:1] == own && (!sh_r[0] || armed_r)) begin
                ok = 1'b1;
                txm_nxt = sh_r[0];
                lpos_nxt = 2'd1;
                ridx_nxt = 8'h00;
              end
            end else if (ham && !half_r) begin
              ok = cw_ok;
              nib_nxt = cw_nib;
              half_nxt = 1'b1;
            end else if (!ham || cw_ok) begin
              half_nxt = 1'b0;
              if (lpos_r == 2'd1) begin
                ok = (lb == {own, 1'b0});
                lpos_nxt = 2'd2;
              end else if (lpos_r == 2'd2) begin
                ok = (seq_len(lb) != 8'h00);
                cmd_nxt = lb;
                armed_nxt = ok;
                widx_nxt = 8'h00;
                lpos_nxt = 2'd3;
              end else if (!is_wr) begin
                ok = 1'b0;
              end else if (is_dir && widx_r == 8'h00) begin
                ok = in_range(lb);
                ptr_nxt = lb;
              end else if (widx_w >= seq_len(cmd_r)) begin
                ok = 1'b1;
              end else if (is_dir && !in_range(wa)) begin
                ok = 1'b0;
              end else if (pair && widx_r == 8'h00) begin
                ok = 1'b1;
                hold_nxt = lb;
              end else if (pair && widx_r == 8'h01) begin
                ok = (cnt_r == '0);
                push = ok;
                pend_nxt = ok;
                pdat_nxt = lb;
                push_ent = {1'b0, `FULL_MASK, `REG_CHAN_CFG1, hold_r};
              end else begin
                ok = fifo_rdy;
                push = ok;
                push_ent = {cmd_r == `CMD_PROGRAM_ONETIME_CELLS,
                            (cmd_r == `CMD_WRITE_PRESCALER_BIT) ?
                            `PRESCALE_MASK : `FULL_MASK, wa, lb};
              end
              if (ok && lpos_r == 2'd3 && widx_r != 8'hff) begin
                widx_nxt = widx_r + 8'h01;
              end
            end
            // nack leaves the link idle until start or stop
            st_nxt = ok ? S_ACK : S_IDLE;
            oe_b_nxt = !ok;
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            bit_nxt = 4'h0;
            if (txm_r) begin
              st_nxt = S_TX;
              sh_nxt = tx_load;
              oe_b_nxt = tx_load[7];
            end else begin
              st_nxt = S_RX;
              oe_b_nxt = 1'b1;
            end
          end
        end
        S_TX: begin
          if (scl_fall) begin
            bit_nxt = bit_r + 4'h1;
            sh_nxt = {sh_r[6:0], 1'b0};
            oe_b_nxt = (bit_r == 4'h7) | sh_r[6];
            if (bit_r == 4'h7) begin
              st_nxt = S_MACK;
            end
          end
        end
        S_MACK: begin
          if (scl_rise) begin
            mack_nxt = sda_q_r[1];
            if (!sda_q_r[1]) begin
              half_nxt = ham && !half_r;
              if (!ham || half_r) begin
                ridx_nxt = ridx_r + 8'h01;
              end
            end
          end
          if (scl_fall) begin
            bit_nxt = 4'h0;
            st_nxt = mack_r ? S_IDLE : S_TX;
            sh_nxt = tx_load;
            oe_b_nxt = mack_r | tx_load[7];
          end
        end
        default: begin
          oe_b_nxt = 1'b1;
        end
      endcase
    end
  end

  // write buffer: a full buffer turns into a nack on the link
  always_comb begin
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push && fifo_rdy) begin
      mem_nxt[wp_r] = push_ent;
      wp_nxt = (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + PW'(1);
    end
    if (WR_VALID && WR_READY) begin
      rp_nxt = (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + PW'(1);
    end
    cnt_nxt = cnt_r + (PW + 1)'(push && fifo_rdy) -
              (PW + 1)'(WR_VALID && WR_READY);
  end

  assign WR_VALID = (cnt_r != '0);
  assign {WR_BURN, WR_MASK, WR_ADDR, WR_DATA} = mem_r[rp_r];

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      scl_q_r <= 3'h7;
      sda_q_r <= 3'h7;
      st_r <= S_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      oe_b_r <= 1'b1;
      lpos_r <= 2'd0;
      half_r <= 1'b0;
      nib_r <= 4'h0;
      cmd_r <= 8'hff;
      armed_r <= 1'b0;
      txm_r <= 1'b0;
      widx_r <= 8'h00;
      ridx_r <= 8'h00;
      ptr_r <= 8'h00;
      hold_r <= 8'h00;
      pend_r <= 1'b0;
      pdat_r <= 8'h00;
      mack_r <= 1'b1;
      rda_r <= 8'h00;
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      scl_q_r <= scl_q_nxt;
      sda_q_r <= sda_q_nxt;
      st_r <= st_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      oe_b_r <= oe_b_nxt;
      lpos_r <= lpos_nxt;
      half_r <= half_nxt;
      nib_r <= nib_nxt;
      cmd_r <= cmd_nxt;
      armed_r <= armed_nxt;
      txm_r <= txm_nxt;
      widx_r <= widx_nxt;
      ridx_r <= ridx_nxt;
      ptr_r <= ptr_nxt;
      hold_r <= hold_nxt;
      pend_r <= pend_nxt;
      pdat_r <= pdat_nxt;
      mack_r <= mack_nxt;
      rda_r <= rda_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      mem_r <= mem_nxt;
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  chk_pair_order: assert property (
    push && pair && push_ent[15:8] == `REG_CHAN_CFG1 |=>
    push && push_ent[15:8] == `REG_CHAN_CFG2)
    else $error("config pair not pushed back to back");
  chk_first_held: assert property (
    push && !pend_r && pair && push_ent[15:8] == `REG_CHAN_CFG1
    |-> widx_r == 8'h01)
    else $error("first config pushed before second byte");
  chk_bad_cmd: assert property (
    dec && lpos_r == 2'd2 && (!ham || half_r) &&
    (!ham || cw_ok) && seq_len(lb) == 8'h00 |=> oe_b_r && st_r == S_IDLE)
    else $error("unknown command acknowledged");
  chk_addr_nack: assert property (
    dec && lpos_r == 2'd1 && !ham && sh_r != {own, 1'b0} |=> oe_b_r)
    else $error("foreign repeated address acknowledged");
  chk_prescale_mask: assert property (
    push && !pend_r && cmd_r == `CMD_WRITE_PRESCALER_BIT |->
    push_ent[23:16] == `PRESCALE_MASK && push_ent[15:8] == `REG_FAULT1)
    else $error("prescaler write not masked to bit seven");
  chk_bad_codeword: assert property (
    dec && lpos_r != 2'd0 && ham && !cw_ok |-> !(push && !pend_r) ##1
    oe_b_r && st_r == S_IDLE)
    else $error("invalid codeword accepted");
  chk_tx_high: assert property (
    st_r == S_TX && $past(st_r) != S_TX && ham && !half_r && !$past(half_r)
    |-> sh_r == nib_encode($past(tx_byte[7:4])))
    else $error("read byte high codeword wrong");
  chk_burn_only: assert property (
    push && push_ent[24] |-> cmd_r == `CMD_PROGRAM_ONETIME_CELLS)
    else $error("burn flag on a plain write");
  chk_gain_range: assert property (
    push && cmd_r == `CMD_WRITE_GAINS |-> push_ent[15:8] >= `REG_GAIN_BASE
    && push_ent[15:8] < `REG_GAIN_BASE + `GAIN_COUNT)
    else $error("gain write outside gain registers");
  chk_fifo_bound: assert property (
    cnt_r <= (PW + 1)'(DEPTH))
    else $error("write buffer count out of bounds");
  chk_head_stands: assert property (
    WR_VALID && !WR_READY |=>
    WR_VALID && $stable({WR_BURN, WR_MASK, WR_ADDR, WR_DATA}))
    else $error("stalled write entry lost or changed");
endmodule

//--- testbench/i2c_master.sv
// link master model driving the decoder's bus pins
`timescale 1ns/100ps
module i2c_master (
  input wire logic clk,
  input wire logic prot,
  input wire logic dev_out,
  input wire logic dev_oe_b,
  output logic scl,
  output logic sda
);
  localparam logic [7:0] CW [16] = '{8'h00, 8'h1e, 8'h27, 8'h39, 8'h55,
    8'h4b, 8'h72, 8'h6c, 8'h93, 8'h8d, 8'hb4, 8'haa, 8'hc6, 8'hd8,
    8'he1, 8'hff};
  logic rel;
  int q = 4;
  // pull-up: a released line reads high
  assign sda = rel & (dev_oe_b | dev_out);
  initial begin
    scl = 1'b1;
    rel = 1'b1;
  end
  function automatic logic [7:0] code(input logic [3:0] n);
    return CW[n];
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // scl only moves inside frames, data changes while scl low
  task automatic bit_io(input logic b, output logic s);
    rel <= b;
    tick(q);
    scl <= 1'b1;
    tick(q);
    #1 s = sda;
    tick(q);
    scl <= 1'b0;
    tick(q);
  endtask
  task automatic start();
    rel <= 1'b1;
    tick(q);
    scl <= 1'b1;
    tick(q);
    rel <= 1'b0;
    tick(q);
    scl <= 1'b0;
    tick(q);
  endtask
  task automatic stop();
    rel <= 1'b0;
    tick(q);
    scl <= 1'b1;
    tick(q);
    rel <= 1'b1;
    tick(2 * q);
  endtask
  task automatic raw_wr(input logic [7:0] b, output logic nk);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, nk);
  endtask
  task automatic raw_rd(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(last, s);
  endtask
  task automatic wr(input logic [7:0] b, output logic nk);
    logic a1;
    logic a2;
    if (prot) begin
      raw_wr(code(b[7:4]), a1);
      raw_wr(code(b[3:0]), a2);
      nk = a1 | a2;
    end else begin
      raw_wr(b, nk);
    end
  endtask
  // only the very last codeword gets a nack
  task automatic rd(input logic last, output logic [15:0] v);
    logic [7:0] h;
    logic [7:0] l;
    h = 8'h00;
    if (prot) begin
      raw_rd(1'b0, h);
    end
    raw_rd(last, l);
    v = {h, l};
  endtask
endmodule

//--- testbench/testbench.sv
// self-checking bench for the bus command decoder
`timescale 1ns/100ps
`define CHECK(g, e) check_eq(32'(g), 32'(e))
module testbench;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] m;
    logic b;
  } ent_t;
  typedef struct {
    logic [7:0] cmd;
    int n;
    logic [7:0] a0;
    logic [7:0] m;
    logic b;
    logic rd;
  } row_t;
  localparam logic [7:0] OWN_W = 8'h46;
  localparam int LIMIT = 90000;
  logic CORE_CLK = 1'b0;
  logic RST_B = 1'b0;
  logic WR_READY = 1'b1;
  logic [7:0] SETTING_BYTE = 8'h03;
  logic [7:0] RD_DATA;
  logic SDA_OUT, SDA_OE_B, WR_VALID, WR_BURN;
  logic [7:0] RD_ADDR, WR_ADDR, WR_DATA, WR_MASK;
  wire scl_w, sda_w;
  logic [7:0] regs [256];
  ent_t log_q [$];
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  int base;
  logic nk;
  logic [7:0] cmds [3] = '{8'h28, 8'h05, 8'hff};
  row_t rows [13] = '{
    '{8'h00, 2, 8'h00, 8'hff, 1'b0, 1'b0},
    '{8'h01, 12, 8'h02, 8'hff, 1'b0, 1'b0},
    '{8'h02, 14, 8'h00, 8'hff, 1'b0, 1'b0},
    '{8'h03, 1, 8'h0e, 8'h80, 1'b0, 1'b0},
    '{8'h20, 4, 8'h20, 8'hff, 1'b0, 1'b0},
    '{8'h21, 4, 8'h20, 8'hff, 1'b1, 1'b0},
    '{8'h81, 3, 8'h05, 8'hff, 1'b0, 1'b0},
    '{8'h08, 1, 8'h00, 8'h00, 1'b0, 1'b1},
    '{8'h09, 2, 8'h00, 8'h00, 1'b0, 1'b1},
    '{8'h0a, 17, 8'h00, 8'h00, 1'b0, 1'b1},
    '{8'h0b, 12, 8'h00, 8'h00, 1'b0, 1'b1},
    '{8'h81, 3, 8'h03, 8'h00, 1'b0, 1'b1},
    '{8'h28, 5, 8'h00, 8'h00, 1'b0, 1'b1}};
  always #2.5 CORE_CLK = ~CORE_CLK;
  assign RD_DATA = regs[RD_ADDR];
  i2c_master mst (.clk(CORE_CLK), .prot(SETTING_BYTE[7]),
    .dev_out(SDA_OUT), .dev_oe_b(SDA_OE_B), .scl(scl_w), .sda(sda_w));
  led_bus_command_decoder led_bus_command_decoder_inst (
    .CORE_CLK(CORE_CLK), .RST_B(RST_B), .SCL_IN(scl_w), .SDA_IN(sda_w),
    .SDA_OUT(SDA_OUT), .SDA_OE_B(SDA_OE_B), .SETTING_BYTE(SETTING_BYTE),
    .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA), .WR_VALID(WR_VALID),
    .WR_READY(WR_READY), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA),
    .WR_MASK(WR_MASK), .WR_BURN(WR_BURN));
  // register side: masked update, log of every entry taken
  always @(posedge CORE_CLK) begin
    if (WR_VALID === 1'b1 && WR_READY === 1'b1) begin
      log_q.push_back({WR_ADDR, WR_DATA, WR_MASK, WR_BURN});
      regs[WR_ADDR] <= (regs[WR_ADDR] & ~WR_MASK) | (WR_DATA & WR_MASK);
    end
  end
  always @(posedge CORE_CLK) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask
  task automatic check_eq(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("ERROR at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // full read order: enables, status, faults, gains
  function automatic logic [7:0] src(input row_t r, input int i);
    case (r.cmd)
      8'h08: return 8'h10;
      8'h09: return 8'(8'h0e + i);
      8'h0b: return 8'(8'h02 + i);
      8'h28: return i == 0 ? 8'h13 : 8'(8'h1f + i);
      8'h0a: return i < 2 ? 8'(8'h11 + i) : i == 2 ? 8'h10 :
        i < 5 ? 8'(8'h0b + i) : 8'(i - 3);
      default: return 8'(r.a0 + i);
    endcase
  endfunction
  task automatic head(input logic [7:0] c, output logic nk);
    logic a0;
    logic a1;
    logic a2;
    mst.start();
    mst.raw_wr(OWN_W, a0);
    mst.wr(OWN_W, a1);
    mst.wr(c, a2);
    nk = a0 | a1 | a2;
  endtask
  task automatic run_row(input row_t r);
    logic k;
    logic [15:0] got;
    logic [15:0] x;
    logic [7:0] e;
    int b0;
    b0 = log_q.size();
    head(r.cmd, k);
    `CHECK(k, 1'b0);
    if (r.cmd == 8'h81) begin
      mst.wr(r.a0, k);
      `CHECK(k, 1'b0);
    end
    if (!r.rd) begin
      for (int i = 0; i < r.n; i++) begin
        mst.wr(8'(8'h91 + i), k);
        `CHECK(k, 1'b0);
      end
      mst.stop();
      tick(8);
      `CHECK(log_q.size() - b0, r.n);
      for (int i = 0; i < r.n; i++) begin
        x = {8'(r.a0 + i), 8'(8'h91 + i)};
        `CHECK(log_q[b0 + i], {x, r.m, r.b});
      end
    end else begin
      mst.start();
      mst.raw_wr(OWN_W | 8'h01, k);
      `CHECK(k, 1'b0);
      for (int i = 0; i < r.n; i++) begin
        e = regs[src(r, i)];
        x = SETTING_BYTE[7] ? {mst.code(e[7:4]), mst.code(e[3:0])} : e;
        mst.rd(i == r.n - 1, got);
        `CHECK(got, x);
      end
      mst.stop();
    end
  endtask
  initial begin
    for (int i = 0; i < 256; i++) begin
      regs[i] = 8'(i * 5 + 3);
    end
    tick(8);
    RST_B <= 1'b1;
    tick(8);
    `CHECK(SDA_OE_B, 1'b1);
    `CHECK(WR_VALID, 1'b0);
    `CHECK({RD_ADDR, WR_ADDR, WR_DATA, WR_MASK}, 32'h0);
    `CHECK({WR_BURN, SDA_OUT}, 2'b00);
    $display("test reset done");
    for (int p = 0; p < 2; p++) begin
      SETTING_BYTE <= {p[0], 7'h03};
      tick(2);
      foreach (rows[k]) begin
        run_row(rows[k]);
        $display("row %0d mode %0d done", k, p);
      end
    end
    // valid high codeword, flipped low one
    base = log_q.size();
    head(8'h01, nk);
    mst.raw_wr(8'h1e, nk);
    `CHECK(nk, 1'b0);
    mst.raw_wr(8'h19, nk);
    `CHECK(nk, 1'b1);
    mst.stop();
    tick(8);
    `CHECK(log_q.size() - base, 0);
    SETTING_BYTE <= 8'h03;
    $display("test codeword done");
    mst.start();
    mst.raw_wr(OWN_W, nk);
    mst.wr(8'h48, nk);
    `CHECK(nk, 1'b1);
    mst.stop();
    // read address with nothing armed is refused
    mst.start();
    mst.raw_wr(8'h47, nk);
    `CHECK(nk, 1'b1);
    mst.stop();
    foreach (cmds[k]) begin
      head(cmds[k], nk);
      `CHECK(nk, cmds[k] != 8'h28);
      mst.stop();
    end
    head(8'h81, nk);
    mst.wr(8'h15, nk);
    `CHECK(nk, 1'b1);
    mst.stop();
    // extra byte past the command length is acked, ignored
    base = log_q.size();
    head(8'h03, nk);
    mst.wr(8'h80, nk);
    mst.wr(8'h00, nk);
    `CHECK(nk, 1'b0);
    mst.stop();
    tick(8);
    `CHECK(log_q.size() - base, 1);
    $display("test refusals done");
    // slow master, pair cut after its first byte
    mst.q = 8;
    base = log_q.size();
    head(8'h00, nk);
    mst.wr(8'h5a, nk);
    mst.stop();
    tick(8);
    `CHECK(log_q.size() - base, 0);
    mst.q = 4;
    $display("test pair cut done");
    WR_READY <= 1'b0;
    base = log_q.size();
    head(8'h01, nk);
    for (int i = 0; i < 3; i++) begin
      mst.wr(8'(8'h60 + i), nk);
      `CHECK(nk, i == 2);
    end
    mst.stop();
    `CHECK(WR_VALID, 1'b1);
    WR_READY <= 1'b1;
    tick(8);
    `CHECK(log_q.size() - base, 2);
    `CHECK(log_q[base + 1], {8'h03, 8'h61, 8'hff, 1'b0});
    $display("test buffer full done");
    tally_and_finish();
  end
endmodule
